// >>> rtl/two_wire_port.sv
// two-wire bus controller: slave, master and multimaster, with receive fifo
`timescale 1ns/1ns

module two_wire_fifo
	import two_wire_pkg::*;
#(
	parameter int WIDTH = BYTE_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output      logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output      logic             out_valid,
	input  wire logic             out_ready,
	output      logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
		if (p == AW'(DEPTH - 1)) begin
			return '0;
		end
		return p + AW'(1);
	endfunction

	assign in_ready  = (cnt_q != (AW + 1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= ptr_next(wr_q);
			if (pop) rd_q <= ptr_next(rd_q);
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

// Behaviour
// - enabled slave waits for a start condition before any receive or transmit
// - master generates start and stop and begins transfers to addressed slaves
// - master waits on stretched clock, shortens high on sync, drops on lost arbitration
// - start events seen only when slave role enabled, not for master-only use
// - received 7-bit address compared to own address in hardware, proceed on match
// - address match while sleeping raises a wake pulse
// - first byte after start is 7-bit address plus direction, 1 means read
// - bus clock timing allows rates up to 1 Mbps
// - digital glitch filter on inputs, bypassed while the system sleeps
// - bytes handled one at a time, each completion flagged by an event pulse
// - start, stop, acknowledge and data framing done in hardware
module two_wire_port
	import two_wire_pkg::*;
#(
	parameter int HALF = HALF_CYC,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              slave_en,
	input  wire logic              master_en,
	input  wire logic [ADDR_W-1:0] own_addr,
	input  wire logic              sleep,
	input  wire logic              scl_i,
	output      logic              scl_o,
	output      logic              scl_oe,
	input  wire logic              sda_i,
	output      logic              sda_o,
	output      logic              sda_oe,
	input  wire logic              cmd_valid,
	output      logic              cmd_ready,
	input  wire cmd_t              cmd,
	output      logic              rx_valid,
	input  wire logic              rx_ready,
	output      logic [BYTE_W-1:0] rx_data,
	output      evt_t              evt,
	output      logic              bus_busy,
	output      logic              nack_seen,
	output      logic              master_role
);
	state_t            state_q, state_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic [3:0]        bit_q, bit_d;
	logic [BYTE_W-1:0] shift_q, shift_d;
	logic              sda_drv_q, sda_d;
	logic              hold_q, hold_d;
	logic              rw_q, rw_d;
	logic              mrx_q, mrx_d;
	logic              ack_q, ack_d;
	logic              nack_q, nack_d;
	logic              rs_q, rs_d;
	logic              pend_q, pend_d;
	logic              busy_q;
	evt_t              evt_q, evt_d;
	logic [2:0]        scl_h_q, sda_h_q;
	logic              scl_f_q, sda_f_q, scl_p_q, sda_p_q;

	// three equal samples needed; in sleep the filter clock is gone, so pass raw
	function automatic logic filt(input logic [2:0] h, input logic cur, input logic byp,
			input logic raw);
		if (byp) return raw;
		if (h == FILT_ONES) return BUS_IDLE;
		if (h == FILT_ZEROS) return BUS_LOW;
		return cur;
	endfunction

	always_ff @(posedge clk) begin
		if (!rstn) begin
			scl_h_q <= FILT_ONES;
			sda_h_q <= FILT_ONES;
			scl_f_q <= BUS_IDLE;
			sda_f_q <= BUS_IDLE;
			scl_p_q <= BUS_IDLE;
			sda_p_q <= BUS_IDLE;
		end else begin
			scl_h_q <= {scl_h_q[1:0], scl_i};
			sda_h_q <= {sda_h_q[1:0], sda_i};
			scl_f_q <= filt(scl_h_q, scl_f_q, sleep, scl_i);
			sda_f_q <= filt(sda_h_q, sda_f_q, sleep, sda_i);
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
		end
	end

	wire scl_rise  = scl_f_q & ~scl_p_q;
	wire scl_fall  = ~scl_f_q & scl_p_q;
	wire start_det = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
	wire stop_det  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
	wire addr_hit  = (shift_q[BYTE_W-1:1] == own_addr);
	wire timed     = (state_q inside {ST_M_START, ST_M_LOW, ST_M_STOP1, ST_M_STOP3})
		| ((state_q inside {ST_M_HIGH, ST_M_SCLUP}) & scl_f_q);
	wire tdone     = timed & (cnt_q == CNT_W'(HALF - 1));
	wire first_hi  = (cnt_q == '0) & scl_f_q;
	wire sync_lo   = (cnt_q != '0) & ~scl_f_q;
	wire nxt_ack   = (bit_q == BIT_LAST);
	wire want_push = ((state_q == ST_S_RX) & hold_q) | ((state_q == ST_M_OWN) & pend_q);
	wire fifo_rdy;
	wire cmd_take;

	assign master_role = state_q inside {ST_M_START, ST_M_OWN, ST_M_LOW, ST_M_HIGH,
		ST_M_STOP1, ST_M_SCLUP, ST_M_STOP3};
	assign cmd_ready = ((state_q == ST_IDLE) & master_en & ~busy_q & ~start_det
		& (cmd.op == OP_START)) | ((state_q == ST_M_OWN) & ~pend_q)
		| ((state_q == ST_S_TX) & hold_q);
	assign cmd_take  = cmd_valid & cmd_ready;
	assign scl_o     = BUS_LOW;
	assign sda_o     = BUS_LOW;
	// slave stretches while the fifo or the send data is not ready
	assign scl_oe    = hold_q | (state_q inside {ST_M_OWN, ST_M_LOW, ST_M_STOP1});
	assign sda_oe    = sda_drv_q;
	assign evt       = evt_q;
	assign bus_busy  = busy_q;
	assign nack_seen = nack_q;

	always_comb begin
		state_d = state_q;
		bit_d   = bit_q;
		shift_d = shift_q;
		sda_d   = sda_drv_q;
		hold_d  = hold_q;
		rw_d    = rw_q;
		mrx_d   = mrx_q;
		ack_d   = ack_q;
		nack_d  = nack_q;
		rs_d    = rs_q;
		pend_d  = pend_q;
		evt_d   = '0;
		evt_d.start_seen = start_det & slave_en & ~master_role;
		evt_d.stop_seen  = stop_det;
		case (state_q)
			ST_IDLE: begin
				if (cmd_take) begin
					state_d = ST_M_START;
					sda_d   = 1'b1;
					nack_d  = 1'b0;
				end
			end
			ST_S_ADDR, ST_S_RX: begin
				if (scl_rise) begin
					if (bit_q < BIT_ACK) shift_d = {shift_q[BYTE_W-2:0], sda_f_q};
					bit_d = bit_q + BIT_STEP;
				end
				if (scl_fall && bit_q == BIT_ACK) begin
					if (state_q == ST_S_ADDR) begin
						if (addr_hit) begin
							sda_d          = 1'b1;
							rw_d           = shift_q[0];
							evt_d.addr_hit = 1'b1;
							evt_d.wake     = sleep;
						end else begin
							state_d = ST_WAIT;
						end
					end else begin
						hold_d = 1'b1;
					end
				end
				if (hold_q && fifo_rdy) begin
					hold_d          = 1'b0;
					sda_d           = 1'b1;
					evt_d.byte_done = 1'b1;
				end
				if (scl_fall && bit_q == BIT_END) begin
					sda_d = 1'b0;
					bit_d = BIT_FIRST;
					if (state_q == ST_S_ADDR && rw_q) begin
						state_d = ST_S_TX;
						hold_d  = 1'b1;
					end else begin
						state_d = ST_S_RX;
					end
				end
			end
			ST_S_TX: begin
				if (cmd_take) begin
					hold_d  = 1'b0;
					shift_d = cmd.data;
					sda_d   = ~cmd.data[BYTE_W-1];
				end
				if (scl_rise) begin
					bit_d = bit_q + BIT_STEP;
					if (bit_q == BIT_ACK) begin
						nack_d          = sda_f_q;
						evt_d.byte_done = 1'b1;
						if (sda_f_q) state_d = ST_WAIT;
					end
				end
				if (scl_fall) begin
					if (bit_q < BIT_ACK) begin
						shift_d = {shift_q[BYTE_W-2:0], 1'b0};
						sda_d   = ~shift_q[BYTE_W-2];
					end else if (bit_q == BIT_ACK) begin
						sda_d = 1'b0;
					end else begin
						bit_d  = BIT_FIRST;
						hold_d = 1'b1;
					end
				end
			end
			ST_M_START: begin
				if (tdone) state_d = ST_M_OWN;
			end
			ST_M_OWN: begin
				if (pend_q && fifo_rdy) pend_d = 1'b0;
				if (cmd_take) begin
					case (cmd.op)
						OP_START: begin
							rs_d    = 1'b1;
							sda_d   = 1'b0;
							state_d = ST_M_STOP1;
						end
						OP_STOP: begin
							rs_d    = 1'b0;
							sda_d   = 1'b1;
							state_d = ST_M_STOP1;
						end
						OP_WRITE: begin
							// after a refused byte further writes are dropped
							if (!nack_q) begin
								shift_d = cmd.data;
								mrx_d   = 1'b0;
								bit_d   = BIT_FIRST;
								sda_d   = ~cmd.data[BYTE_W-1];
								state_d = ST_M_LOW;
							end
						end
						default: begin
							mrx_d   = 1'b1;
							ack_d   = cmd.ack;
							bit_d   = BIT_FIRST;
							sda_d   = 1'b0;
							state_d = ST_M_LOW;
						end
					endcase
				end
			end
			ST_M_LOW: begin
				if (tdone) state_d = ST_M_HIGH;
			end
			ST_M_HIGH: begin
				if (first_hi) begin
					if (bit_q == BIT_ACK) begin
						if (!mrx_q) nack_d = sda_f_q;
					end else if (mrx_q) begin
						shift_d = {shift_q[BYTE_W-2:0], sda_f_q};
					end else if (!sda_drv_q && !sda_f_q) begin
						state_d        = ST_WAIT;
						sda_d          = 1'b0;
						evt_d.arb_lost = 1'b1;
					end
				end
				if (state_d == ST_M_HIGH && (tdone || sync_lo)) begin
					if (bit_q == BIT_ACK) begin
						state_d         = ST_M_OWN;
						sda_d           = 1'b0;
						pend_d          = mrx_q;
						evt_d.byte_done = 1'b1;
					end else begin
						bit_d   = bit_q + BIT_STEP;
						state_d = ST_M_LOW;
						sda_d   = mrx_q ? (nxt_ack & ack_q) : (~nxt_ack & ~shift_q[BYTE_W-2]);
						if (!mrx_q) shift_d = {shift_q[BYTE_W-2:0], 1'b0};
					end
				end
			end
			ST_M_STOP1: begin
				if (tdone) state_d = ST_M_SCLUP;
			end
			ST_M_SCLUP: begin
				if (tdone) begin
					if (rs_q) begin
						state_d = ST_M_START;
						sda_d   = 1'b1;
						nack_d  = 1'b0;
					end else begin
						state_d = ST_M_STOP3;
						sda_d   = 1'b0;
					end
				end
			end
			ST_M_STOP3: begin
				if (tdone) state_d = ST_IDLE;
			end
			ST_WAIT: begin
			end
			default: state_d = ST_IDLE;
		endcase
		// repeated start toward the slave needs no case of its own, it restarts address phase
		if (!master_role) begin
			if (stop_det) begin
				state_d = ST_IDLE;
				sda_d   = 1'b0;
				hold_d  = 1'b0;
			end
			if (start_det) begin
				state_d = slave_en ? ST_S_ADDR : ST_WAIT;
				bit_d   = BIT_FIRST;
				sda_d   = 1'b0;
				hold_d  = 1'b0;
				rw_d    = 1'b0;
			end
		end
	end

	assign cnt_d = (state_d != state_q) ? '0 : (timed ? cnt_q + CNT_W'(1) : cnt_q);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q   <= ST_IDLE;
			cnt_q     <= '0;
			bit_q     <= BIT_FIRST;
			shift_q   <= '0;
			sda_drv_q <= 1'b0;
			hold_q    <= 1'b0;
			rw_q      <= 1'b0;
			mrx_q     <= 1'b0;
			ack_q     <= 1'b0;
			nack_q    <= 1'b0;
			rs_q      <= 1'b0;
			pend_q    <= 1'b0;
			busy_q    <= 1'b0;
			evt_q     <= '0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			bit_q     <= bit_d;
			shift_q   <= shift_d;
			sda_drv_q <= sda_d;
			hold_q    <= hold_d;
			rw_q      <= rw_d;
			mrx_q     <= mrx_d;
			ack_q     <= ack_d;
			nack_q    <= nack_d;
			rs_q      <= rs_d;
			pend_q    <= pend_d;
			busy_q    <= start_det | (busy_q & ~stop_det);
			evt_q     <= evt_d;
		end
	end

	two_wire_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (want_push),
		.in_ready  (fifo_rdy),
		.in_data   (shift_q),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);
endmodule

// >>> rtl/two_wire_pkg.sv
// shared types and constants for the two-wire bus controller
package two_wire_pkg;

	localparam int CLK_HZ     = 100_000_000;
	localparam int BUS_HZ     = 1_000_000;
	// least half period of the bus clock, rounded up to whole cycles
	localparam int HALF_CYC   = (CLK_HZ + 2 * BUS_HZ - 1) / (2 * BUS_HZ);
	localparam int CNT_W      = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int BYTE_W     = 8;
	localparam int ADDR_W     = 7;

	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST  = 4'h7;
	localparam logic [3:0] BIT_ACK   = 4'h8;
	localparam logic [3:0] BIT_END   = 4'h9;
	localparam logic [3:0] BIT_STEP  = 4'h1;

	localparam logic [2:0] FILT_ONES  = 3'h7;
	localparam logic [2:0] FILT_ZEROS = 3'h0;
	localparam logic       BUS_IDLE   = 1'h1;
	localparam logic       BUS_LOW    = 1'h0;

	typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} op_t;

	// ack: for OP_READ, 1 answers the byte with an acknowledge
	typedef struct packed {
		op_t               op;
		logic              ack;
		logic [BYTE_W-1:0] data;
	} cmd_t;

	typedef struct packed {
		logic byte_done;
		logic start_seen;
		logic stop_seen;
		logic addr_hit;
		logic arb_lost;
		logic wake;
	} evt_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_WAIT, ST_S_ADDR, ST_S_RX, ST_S_TX,
		ST_M_START, ST_M_OWN, ST_M_LOW, ST_M_HIGH, ST_M_STOP1, ST_M_SCLUP, ST_M_STOP3
	} state_t;

endpackage

// >>> testbench/two_wire_port_sva.sv
// port assertions for the two-wire bus controller
`timescale 1ns/1ns
module two_wire_checker
	import two_wire_pkg::*;
#(
	parameter int HALF  = HALF_CYC,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              slave_en,
	input wire logic              master_en,
	input wire logic              sleep,
	input wire logic              scl_oe,
	input wire logic              sda_oe,
	input wire logic              cmd_valid,
	input wire logic              cmd_ready,
	input wire cmd_t              cmd,
	input wire logic              rx_valid,
	input wire logic              rx_ready,
	input wire logic [BYTE_W-1:0] rx_data,
	input wire evt_t              evt,
	input wire logic              bus_busy,
	input wire logic              master_role
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	chk_idle_quiet: assert property (
		!bus_busy && !$past(bus_busy) && !master_role |-> !sda_oe && !scl_oe)
		else $error("idle bus pulled");
	chk_idle_cmd: assert property (
		cmd_ready && !bus_busy && !master_role |-> cmd.op == OP_START && master_en)
		else $error("non-start taken from idle");
	// bound covers HALF up to 50 plus the start hold
	chk_start_busy: assert property (
		cmd_valid && cmd_ready && cmd.op == OP_START && !bus_busy |-> ##[1:60] bus_busy)
		else $error("start never took the bus");
	chk_own_start: assert property (evt.start_seen |-> slave_en && !master_role)
		else $error("start reported without slave role");
	chk_hit_ack: assert property (evt.addr_hit |-> ##[0:3] sda_oe)
		else $error("address hit without acknowledge");
	chk_wake_sleep: assert property (evt.wake |-> sleep && slave_en)
		else $error("wake while awake");
	chk_arb_release: assert property (evt.arb_lost |-> ##[0:2] !sda_oe && !scl_oe)
		else $error("lines held after lost arbitration");
	chk_stop_free: assert property (evt.stop_seen |-> ##[0:1] !bus_busy)
		else $error("busy after stop");
	chk_rx_hold: assert property (
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
		else $error("receive head changed while stalled");
	cover property (evt.addr_hit);
	cover property (evt.arb_lost);
	cover property (evt.byte_done && master_role);
endmodule

bind two_wire_port two_wire_checker #(.HALF(HALF), .DEPTH(DEPTH)) chk_u (
	.clk(clk), .rstn(rstn), .slave_en(slave_en), .master_en(master_en),
	.sleep(sleep), .scl_oe(scl_oe), .sda_oe(sda_oe), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd(cmd), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.rx_data(rx_data), .evt(evt), .bus_busy(bus_busy), .master_role(master_role)
);

// >>> testbench/bus_agent.sv
// far-side bus party: outside master plus acknowledging slave
`timescale 1ns/1ns
module bus_agent #(
	parameter int H = 8
) (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic ack_en,
	input  wire logic sda_hold,
	output      logic scl_pull,
	output      logic sda_pull
);
	logic       m_sda;
	logic       rs_ack;
	logic       ps;
	logic       pd;
	logic [3:0] cnt;
	logic [3:0] nx;
	logic [7:0] sh;
	logic [7:0] cap;
	// released lines rise through the pull-ups
	assign sda_pull = m_sda | rs_ack | sda_hold;
	assign nx = (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
	initial begin
		scl_pull = 1'h0;
		m_sda = 1'h0;
		rs_ack = 1'h0;
		cnt = 4'h0;
	end
	// counts falls after a start; the ninth clock carries our acknowledge
	always @(negedge clk) begin
		ps <= scl;
		pd <= sda;
		if (ps && scl && pd && !sda) begin
			cnt <= 4'h0;
		end else if (ps && !scl) begin
			cnt <= nx;
			rs_ack <= ack_en && nx == 4'h9;
			if (nx == 4'h9) cap <= sh;
		end
		if (!ps && scl) sh <= {sh[6:0], sda};
	end
	task automatic half();
		repeat (H) @(negedge clk);
	endtask
	// the other side may stretch the clock, so wait with a bound
	task automatic up();
		scl_pull = 1'h0;
		for (int n = 0; n < 3000 && !scl; n++) @(negedge clk);
	endtask
	task automatic rise(output logic b);
		up();
		half();
		b = sda;
		scl_pull = 1'h1;
	endtask
	// only called from a free bus, never as a repeated start
	task automatic start();
		m_sda = 1'h1;
		half();
		scl_pull = 1'h1;
	endtask
	// 7-bit addresses only; no 10-bit second byte is ever sent
	task automatic send(input logic [7:0] d, output logic a);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			m_sda = !d[i];
			half();
			rise(b);
		end
		m_sda = 1'h0;
		half();
		rise(a);
	endtask
	task automatic recv(input logic nak, output logic [7:0] d);
		logic b;
		m_sda = 1'h0;
		for (int i = 7; i >= 0; i--) begin
			half();
			rise(b);
			d[i] = b;
		end
		m_sda = !nak;
		half();
		rise(b);
		m_sda = 1'h0;
	endtask
	task automatic stop();
		m_sda = 1'h1;
		half();
		up();
		half();
		m_sda = 1'h0;
		half();
	endtask
endmodule

// >>> testbench/two_wire_port_tb_top.sv
// self-checking bench for the two-wire bus controller
`timescale 1ns/1ns
module two_wire_port_tb_top
	import two_wire_pkg::*;
;
	logic              clk;
	logic              rstn;
	logic              slave_en;
	logic              master_en;
	logic [ADDR_W-1:0] own_addr;
	logic              sleep;
	logic              scl_i;
	logic              sda_i;
	logic              scl_oe;
	logic              sda_oe;
	logic              cmd_valid;
	logic              cmd_ready;
	cmd_t              cmd;
	logic              rx_valid;
	logic              rx_ready;
	logic [BYTE_W-1:0] rx_data;
	evt_t              evt;
	evt_t              seen;
	logic              bus_busy;
	logic              nack_seen;
	logic              master_role;
	logic              ack_en;
	logic              sda_hold;
	logic              ag_scl;
	logic              ag_sda;
	logic              a;
	logic [7:0]        d;
	int                errors;
	int                check_count;
	assign scl_i = !(scl_oe | ag_scl);
	assign sda_i = !(sda_oe | ag_sda);
	two_wire_port #(.HALF(4), .DEPTH(8)) dut_u (
		.clk(clk), .rstn(rstn), .slave_en(slave_en), .master_en(master_en),
		.own_addr(own_addr), .sleep(sleep), .scl_i(scl_i), .scl_o(), .scl_oe(scl_oe),
		.sda_i(sda_i), .sda_o(), .sda_oe(sda_oe), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .evt(evt), .bus_busy(bus_busy), .nack_seen(nack_seen),
		.master_role(master_role)
	);
	bus_agent #(.H(8)) ag (.clk(clk), .scl(scl_i), .sda(sda_i), .ack_en(ack_en),
		.sda_hold(sda_hold), .scl_pull(ag_scl), .sda_pull(ag_sda));
	// event pulses last one cycle, so keep them until a scenario looks
	always @(posedge clk) seen <= seen | evt;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("wrong value at %0t: %h, expected %h", $time, s, e);
		end
	endtask
	task automatic chkb(input logic s, input logic e);
		chk({7'h00, s}, {7'h00, e});
	endtask
	task automatic close_out();
		if (errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic send_cmd(input op_t op, input logic [7:0] v, input bit w);
		cmd_valid = 1'h1;
		cmd = '{op: op, ack: 1'h0, data: v};
		seen.byte_done = 1'h0;
		// ready judged off the edge; it stands until the taking rising edge
		for (int n = 0; n < 3000 && cmd_ready !== 1'h1; n++) @(negedge clk);
		@(negedge clk);
		cmd_valid = 1'h0;
		for (int n = 0; n < 3000 && w && seen.byte_done !== 1'h1; n++) @(negedge clk);
	endtask
	task automatic pop(input logic [7:0] e);
		for (int n = 0; n < 3000 && rx_valid !== 1'h1; n++) @(negedge clk);
		chk(rx_data, e);
		rx_ready = 1'h1;
		@(negedge clk);
		rx_ready = 1'h0;
	endtask
	task automatic idle();
		for (int n = 0; n < 500 && bus_busy !== 1'h0; n++) @(negedge clk);
		repeat (10) @(negedge clk);
		chkb(bus_busy, 1'h0);
	endtask
	task automatic t_glitch();
		seen = '0;
		sda_hold = 1'h1;
		@(negedge clk);
		sda_hold = 1'h0;
		repeat (10) @(negedge clk);
		chkb(seen.start_seen, 1'h0);
	endtask
	task automatic t_slave_fill();
		seen = '0;
		ag.start();
		ag.send({7'h2C, 1'h0}, a);
		chkb(a, 1'h0);
		chkb(seen.start_seen, 1'h1);
		chkb(seen.addr_hit, 1'h1);
		for (int i = 0; i < 8; i++) begin
			ag.send(8'h30 + 8'(i), a);
			chkb(a, 1'h0);
		end
		fork
			ag.send(8'h38, a);
			begin
				repeat (300) @(negedge clk);
				chkb(scl_oe, 1'h1);
				for (int i = 0; i < 9; i++) pop(8'h30 + 8'(i));
			end
		join
		chkb(a, 1'h0);
		ag.stop();
		idle();
		chkb(seen.stop_seen, 1'h1);
	endtask
	task automatic t_bad_addr();
		seen = '0;
		ag.start();
		ag.send({7'h2D, 1'h0}, a);
		chkb(a, 1'h1);
		chkb(seen.addr_hit, 1'h0);
		ag.stop();
		idle();
	endtask
	task automatic t_slave_read();
		sleep = 1'h1;
		seen = '0;
		ag.start();
		ag.send({7'h2C, 1'h1}, a);
		chkb(seen.wake, 1'h1);
		fork
			ag.recv(1'h1, d);
			send_cmd(OP_WRITE, 8'h96, 1'b0);
		join
		chk(d, 8'h96);
		ag.stop();
		idle();
		sleep = 1'h0;
	endtask
	task automatic t_master_only();
		slave_en = 1'h0;
		master_en = 1'h1;
		seen = '0;
		ag.start();
		repeat (20) @(negedge clk);
		chkb(seen.start_seen, 1'h0);
		chkb(bus_busy, 1'h1);
		ag.stop();
		idle();
	endtask
	task automatic t_master_write(input logic ack);
		ack_en = ack;
		seen = '0;
		send_cmd(OP_START, 8'h00, 1'b0);
		send_cmd(OP_WRITE, {7'h2D, 1'h0}, 1'b1);
		chk(ag.cap, {7'h2D, 1'h0});
		chkb(nack_seen, !ack);
		send_cmd(OP_WRITE, 8'hC3, 1'b1);
		if (ack) chk(ag.cap, 8'hC3);
		chkb(seen.start_seen, 1'h0);
		send_cmd(OP_STOP, 8'h00, 1'b0);
		idle();
	endtask
	task automatic t_arb();
		ack_en = 1'h0;
		seen = '0;
		send_cmd(OP_START, 8'h00, 1'b0);
		sda_hold = 1'h1;
		send_cmd(OP_WRITE, 8'hFF, 1'b0);
		for (int n = 0; n < 500 && seen.arb_lost !== 1'h1; n++) @(negedge clk);
		chkb(seen.arb_lost, 1'h1);
		// releasing data while the clock floats high is itself a stop
		sda_hold = 1'h0;
		idle();
	endtask
	initial begin
		clk = 1'h0;
		forever #5 clk = !clk;
	end
	initial begin
		errors = 0;
		check_count = 0;
		rstn = 1'h0;
		slave_en = 1'h1;
		master_en = 1'h0;
		own_addr = 7'h2C;
		sleep = 1'h0;
		cmd_valid = 1'h0;
		cmd = '{op: OP_START, ack: 1'h0, data: 8'h00};
		rx_ready = 1'h0;
		ack_en = 1'h0;
		sda_hold = 1'h0;
		seen = '0;
		repeat (6) @(negedge clk);
		rstn = 1'h1;
		repeat (8) @(negedge clk);
		t_glitch();
		t_slave_fill();
		t_bad_addr();
		t_slave_read();
		t_master_only();
		t_master_write(1'h1);
		t_master_write(1'h0);
		t_arb();
		close_out();
	end
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		close_out();
	end
endmodule
